// ---- inc/ioport_pkg.sv ----
// Purpose: Shared constants and carrier types for the I/O port block.
// Assumes: 32-bit AXI4-Lite register access, one register per word.
// Notes: Offsets are byte addresses.
package ioport_pkg;
    localparam logic [7:0] OFF_PORT0 = 8'h00;
    localparam logic [7:0] OFF_PORT1 = 8'h04;
    localparam logic [7:0] OFF_PORT2 = 8'h08;
    localparam logic [7:0] OFF_PORT3 = 8'h0c;
    localparam logic [7:0] OFF_P0MODE = 8'h10;
    localparam logic [7:0] OFF_P1MODE = 8'h14;
    localparam logic [7:0] OFF_P2MODE = 8'h18;
    localparam logic [7:0] OFF_P3MODE = 8'h1c;
    localparam logic [7:0] OFF_PCFG = 8'h20;
    localparam logic [7:0] OFF_IRQEDGE = 8'h24;
    localparam logic [7:0] OFF_T8CTL = 8'h28;
    localparam logic [7:0] OFF_TCCTL = 8'h2c;
    localparam logic [7:0] OFF_T16CTL = 8'h30;
    localparam logic [7:0] OFF_STATUS = 8'h34;
    localparam logic [7:0] OFF_MASK = 8'h38;
    localparam logic [7:0] OFF_STOP = 8'h3c;
    localparam int PCFG_P1_OD = 1;
    localparam int PCFG_P0_OD = 2;
    localparam int PCFG_P2_OD = 3;
    localparam int PCFG_CMP1_OUT = 0;
    localparam int PCFG_CMP2_OUT = 4;
    localparam int P3MODE_ANALOG = 1;
    localparam int IRQ_EDGE_LO = 6;
    localparam int IRQ_EDGE_HI = 7;
    localparam int TCC_SEL_LO = 4;
    localparam int TCC_SEL_HI = 5;
    localparam int TCC_SRC_P20 = 6;
    localparam int T_OUT_EN = 0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Edge choice for the two comparator-capable inputs.
    typedef enum logic [1:0] {
        EDGE_RISE = 2'b00,
        EDGE_FALL = 2'b01,
        EDGE_BOTH = 2'b10,
        EDGE_BOTH2 = 2'b11
    } edge_sel_t;
    // One eight-bit bidirectional port at the pins.
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] pull_en;
    } pin_drive_t;
    // Counter/timer signals routed to port 3.
    typedef struct packed {
        logic t8_out;
        logic t16_out;
        logic edge_in;
    } timer_link_t;
endpackage : ioport_pkg

// ---- hdl/ioport_top.sv ----
// Purpose: Four I/O ports with comparators, wake gates and AXI4-Lite access.
// Assumes: Pins and comparator results are synchronous to CLK_I.
// Notes: Interrupt status bits clear by writing one.
//
// How it works
// - Port reads return pin levels, not latches, except fourth port bits 7:4 (latch), bit 3 in analog mode (zero) and bits 2:1 (comparators when on).
// - Pull-ups off on pins set as outputs.
// - First port direction chosen per nibble.
// - Config bit D2 selects first port drive.
// - First port inputs after reset and recovery.
// - Second port input after reset and recovery.
// - Config bit D1 selects second port drive.
// - Third port direction set per bit.
// - One drive type for third port outputs.
// - Third port all inputs at reset.
// - AND and OR of third port wake.
// - Timer edge input from port3 bit1 or port2.
// - Fourth port: four inputs, four push-pull outputs.
// - Mode bit 1 enables both comparators.
// - Edge select bits 6, 7 for interrupts.
// - Timer control bits route outputs to fourth port.
// - Comparators off in stop; recovery needs digital.
// - Digital input 3 is D3, raises line one.
// - Config register routes comparators to outputs 4, 7.
`timescale 1ns/1ps
module ioport_top (
    // Clock and reset.
    input wire logic CLK_I,
    input wire logic RSTN_I,
    // AXI4-Lite write.
    input wire logic [7:0] AWADDR_I,
    input wire logic AWVALID_I,
    output logic AWREADY_O,
    input wire logic [31:0] WDATA_I,
    input wire logic [3:0] WSTRB_I,
    input wire logic WVALID_I,
    output logic WREADY_O,
    output logic [1:0] BRESP_O,
    output logic BVALID_O,
    input wire logic BREADY_I,
    // AXI4-Lite read.
    input wire logic [7:0] ARADDR_I,
    input wire logic ARVALID_I,
    output logic ARREADY_O,
    output logic [31:0] RDATA_O,
    output logic [1:0] RRESP_O,
    output logic RVALID_O,
    input wire logic RREADY_I,
    // Ports 0 to 2.
    input wire logic [7:0] P0_IN_I,
    input wire logic [7:0] P1_IN_I,
    input wire logic [7:0] P2_IN_I,
    output ioport_pkg::pin_drive_t P0_O,
    output ioport_pkg::pin_drive_t P1_O,
    output ioport_pkg::pin_drive_t P2_O,
    // Port 3 inputs, comparator results and outputs.
    input wire logic [3:0] P3_IN_I,
    input wire logic CMP1_RESULT_I,
    input wire logic CMP2_RESULT_I,
    output logic [7:4] P3_OUT_O,
    output logic CMP_ENABLE_O,
    // Timer links and low-power control.
    input wire ioport_pkg::timer_link_t TIMER_I,
    input wire logic STOP_MODE_I,
    input wire logic STOP_RECOVERY_I,
    output logic TIMER_EDGE_O,
    output logic WAKE_AND_O,
    output logic WAKE_OR_O,
    output logic [2:0] IRQ_LINES_O,
    output logic [2:0] RECOVERY_SRC_O,
    output logic IRQ_O
);
    ////////////////////////////////////////////////////////////////////////
    logic rst_meta_ff, rst_ff;
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rst_meta_ff <= 1'b0;
            rst_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_ff <= rst_meta_ff;
        end
    end
    wire rstn = rst_ff;

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] p0_lat_ff, p1_lat_ff, p2_lat_ff, p3_lat_ff;
    logic [1:0] p0_dir_ff;
    logic p1_dir_ff;
    logic [7:0] p2_dir_ff;
    logic [7:0] p3_mode_ff, pcfg_ff, irqedge_ff;
    logic [7:0] t8ctl_ff, tcctl_ff, t16ctl_ff;
    logic [2:0] status_ff, mask_ff;
    logic [3:0] p3_prev_ff;
    logic [7:0] aw_addr_ff, ar_addr_ff;
    logic aw_have_ff, w_have_ff;
    logic [31:0] w_data_ff;
    logic [3:0] w_strb_ff;
    logic do_wr, wr_hit;
    logic [31:0] rd_val;
    logic rd_hit;
    logic [3:0] p3_eff;
    logic [2:0] irq_evt;

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            aw_have_ff <= 1'b0;
            w_have_ff <= 1'b0;
            aw_addr_ff <= 8'h00;
            w_data_ff <= 32'h0;
            w_strb_ff <= 4'h0;
            BVALID_O <= 1'b0;
            BRESP_O <= ioport_pkg::RESP_OKAY;
        end else if (!rstn) begin
            aw_have_ff <= 1'b0;
            w_have_ff <= 1'b0;
            BVALID_O <= 1'b0;
        end else begin
            if (AWVALID_I && AWREADY_O) begin
                aw_have_ff <= 1'b1;
                aw_addr_ff <= AWADDR_I;
            end
            if (WVALID_I && WREADY_O) begin
                w_have_ff <= 1'b1;
                w_data_ff <= WDATA_I;
                w_strb_ff <= WSTRB_I;
            end
            if (do_wr) begin
                aw_have_ff <= 1'b0;
                w_have_ff <= 1'b0;
                BVALID_O <= 1'b1;
                BRESP_O <= wr_hit ? ioport_pkg::RESP_OKAY
                                  : ioport_pkg::RESP_SLVERR;
            end else if (BREADY_I) begin
                BVALID_O <= 1'b0;
            end
        end
    end
    assign AWREADY_O = 1'b0 | (rstn & ~aw_have_ff & ~BVALID_O);
    assign WREADY_O = rstn & ~w_have_ff & ~BVALID_O;
    assign do_wr = aw_have_ff & w_have_ff & ~BVALID_O;

    always_comb begin
        wr_hit = 1'b1;
        unique case (aw_addr_ff)
            ioport_pkg::OFF_PORT0, ioport_pkg::OFF_PORT1,
            ioport_pkg::OFF_PORT2, ioport_pkg::OFF_PORT3,
            ioport_pkg::OFF_P0MODE, ioport_pkg::OFF_P1MODE,
            ioport_pkg::OFF_P2MODE, ioport_pkg::OFF_P3MODE,
            ioport_pkg::OFF_PCFG, ioport_pkg::OFF_IRQEDGE,
            ioport_pkg::OFF_T8CTL, ioport_pkg::OFF_TCCTL,
            ioport_pkg::OFF_T16CTL, ioport_pkg::OFF_STATUS,
            ioport_pkg::OFF_MASK: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end
    wire wb = do_wr & w_strb_ff[0];
    wire [7:0] wd = w_data_ff[7:0];

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            p0_lat_ff <= 8'h00;
            p1_lat_ff <= 8'h00;
            p2_lat_ff <= 8'h00;
            p3_lat_ff <= 8'h00;
            p3_mode_ff <= 8'h00;
            pcfg_ff <= 8'h00;
            irqedge_ff <= 8'h00;
            t8ctl_ff <= 8'h00;
            tcctl_ff <= 8'h00;
            t16ctl_ff <= 8'h00;
            mask_ff <= 3'h0;
        end else if (wb) begin
            unique case (aw_addr_ff)
                ioport_pkg::OFF_PORT0: p0_lat_ff <= wd;
                ioport_pkg::OFF_PORT1: p1_lat_ff <= wd;
                ioport_pkg::OFF_PORT2: p2_lat_ff <= wd;
                ioport_pkg::OFF_PORT3: p3_lat_ff <= wd;
                ioport_pkg::OFF_P3MODE: p3_mode_ff <= wd;
                ioport_pkg::OFF_PCFG: pcfg_ff <= wd;
                ioport_pkg::OFF_IRQEDGE: irqedge_ff <= wd;
                ioport_pkg::OFF_T8CTL: t8ctl_ff <= wd;
                ioport_pkg::OFF_TCCTL: tcctl_ff <= wd;
                ioport_pkg::OFF_T16CTL: t16ctl_ff <= wd;
                ioport_pkg::OFF_MASK: mask_ff <= wd[2:0];
                default: ;
            endcase
        end
    end

    // Directions: a set bit means output; reset forces all ports to input, recovery forces ports 0 and 1 only.
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            p0_dir_ff <= 2'b00;
            p1_dir_ff <= 1'b0;
            p2_dir_ff <= 8'h00;
        end else if (STOP_RECOVERY_I) begin
            p0_dir_ff <= 2'b00;
            p1_dir_ff <= 1'b0;
        end else if (wb) begin
            if (aw_addr_ff == ioport_pkg::OFF_P0MODE) begin
                p0_dir_ff <= wd[1:0];
            end
            if (aw_addr_ff == ioport_pkg::OFF_P1MODE) begin
                p1_dir_ff <= wd[0];
            end
            if (aw_addr_ff == ioport_pkg::OFF_P2MODE) begin
                p2_dir_ff <= wd;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] p0_oe, p1_oe, p2_oe;
    assign p0_oe = {{4{p0_dir_ff[1]}}, {4{p0_dir_ff[0]}}};
    assign p1_oe = {8{p1_dir_ff}};
    assign p2_oe = p2_dir_ff;

    // Open drain drives only lows; pull-ups follow the direction.
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            P0_O <= '0;
            P1_O <= '0;
            P2_O <= '0;
        end else begin
            P0_O.out <= pcfg_ff[ioport_pkg::PCFG_P0_OD] ? 8'h00 : p0_lat_ff;
            P0_O.oe <= pcfg_ff[ioport_pkg::PCFG_P0_OD]
                       ? p0_oe & ~p0_lat_ff : p0_oe;
            P0_O.pull_en <= ~p0_oe;
            P1_O.out <= pcfg_ff[ioport_pkg::PCFG_P1_OD] ? 8'h00 : p1_lat_ff;
            P1_O.oe <= pcfg_ff[ioport_pkg::PCFG_P1_OD]
                       ? p1_oe & ~p1_lat_ff : p1_oe;
            P1_O.pull_en <= ~p1_oe;
            P2_O.out <= pcfg_ff[ioport_pkg::PCFG_P2_OD] ? 8'h00 : p2_lat_ff;
            P2_O.oe <= pcfg_ff[ioport_pkg::PCFG_P2_OD]
                       ? p2_oe & ~p2_lat_ff : p2_oe;
            P2_O.pull_en <= ~p2_oe;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    wire analog = p3_mode_ff[ioport_pkg::P3MODE_ANALOG];
    wire cmp_on = analog & ~STOP_MODE_I;
    // In analog mode outside stop, inputs 1 and 2 show comparator results.
    assign p3_eff = {P3_IN_I[3],
                     cmp_on ? CMP2_RESULT_I : P3_IN_I[2],
                     cmp_on ? CMP1_RESULT_I : P3_IN_I[1],
                     P3_IN_I[0]};

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            P3_OUT_O <= 4'h0;
            CMP_ENABLE_O <= 1'b0;
            TIMER_EDGE_O <= 1'b0;
            WAKE_AND_O <= 1'b0;
            WAKE_OR_O <= 1'b0;
            RECOVERY_SRC_O <= 3'h0;
        end else begin
            CMP_ENABLE_O <= cmp_on;
            WAKE_AND_O <= &P2_IN_I;
            WAKE_OR_O <= |P2_IN_I;
            TIMER_EDGE_O <= tcctl_ff[ioport_pkg::TCC_SRC_P20]
                            ? P2_IN_I[0] : P3_IN_I[1];
            // Inputs 3:1 feed stop-mode recovery only in digital mode; analog mode feeds none.
            RECOVERY_SRC_O <= analog ? 3'h0 : P3_IN_I[3:1];
            P3_OUT_O[4] <= pcfg_ff[ioport_pkg::PCFG_CMP1_OUT] ? p3_eff[1]
                         : t8ctl_ff[ioport_pkg::T_OUT_EN] ? TIMER_I.t8_out
                         : p3_lat_ff[4];
            P3_OUT_O[5] <= t16ctl_ff[ioport_pkg::T_OUT_EN] ? TIMER_I.t16_out
                         : p3_lat_ff[5];
            unique case (tcctl_ff[ioport_pkg::TCC_SEL_HI:
                                  ioport_pkg::TCC_SEL_LO])
                2'b00: P3_OUT_O[6] <= p3_lat_ff[6];
                2'b01: P3_OUT_O[6] <= TIMER_I.t8_out & TIMER_I.t16_out;
                2'b10: P3_OUT_O[6] <= TIMER_I.t8_out | TIMER_I.t16_out;
                2'b11: P3_OUT_O[6] <= &P2_IN_I | ~|P2_IN_I;
            endcase
            P3_OUT_O[7] <= pcfg_ff[ioport_pkg::PCFG_CMP2_OUT] ? p3_eff[2]
                         : p3_lat_ff[7];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Edge events: bit0 line zero (input 2), bit1 line one (input 3),
    // bit2 line two (input 1).
    function automatic logic edge_hit(input logic [1:0] sel,
                                      input logic prev, input logic cur);
        edge_hit = (sel == 2'b00) ? (~prev & cur)
                 : (sel == 2'b01) ? (prev & ~cur) : (prev ^ cur);
    endfunction : edge_hit

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            p3_prev_ff <= 4'h0;
        end else begin
            p3_prev_ff <= p3_eff;
        end
    end
    assign irq_evt[0] = edge_hit(irqedge_ff[ioport_pkg::IRQ_EDGE_HI:
                                            ioport_pkg::IRQ_EDGE_LO],
                                 p3_prev_ff[2], p3_eff[2]);
    assign irq_evt[2] = edge_hit(irqedge_ff[ioport_pkg::IRQ_EDGE_HI:
                                            ioport_pkg::IRQ_EDGE_LO],
                                 p3_prev_ff[1], p3_eff[1]);
    assign irq_evt[1] = ~analog & p3_prev_ff[3] & ~p3_eff[3];

    // Set wins over a write-one clear in the same cycle.
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            status_ff <= 3'h0;
            IRQ_LINES_O <= 3'h0;
            IRQ_O <= 1'b0;
        end else if (!rstn) begin
            // Edge history settles before any event may be latched.
            status_ff <= 3'h0;
            IRQ_LINES_O <= 3'h0;
            IRQ_O <= 1'b0;
        end else begin
            status_ff <= (status_ff & ~((wb && aw_addr_ff ==
                          ioport_pkg::OFF_STATUS) ? wd[2:0] : 3'h0))
                         | irq_evt;
            IRQ_LINES_O <= irq_evt;
            IRQ_O <= |(status_ff & mask_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        rd_val = 32'h0;
        rd_hit = 1'b1;
        unique case (ar_addr_ff)
            ioport_pkg::OFF_PORT0: rd_val[7:0] = P0_IN_I;
            ioport_pkg::OFF_PORT1: rd_val[7:0] = P1_IN_I;
            ioport_pkg::OFF_PORT2: rd_val[7:0] = P2_IN_I;
            ioport_pkg::OFF_PORT3: rd_val[7:0] = {p3_lat_ff[7:4],
                                    p3_eff[3] & ~analog, p3_eff[2:0]};
            ioport_pkg::OFF_P0MODE: rd_val[1:0] = p0_dir_ff;
            ioport_pkg::OFF_P1MODE: rd_val[0] = p1_dir_ff;
            ioport_pkg::OFF_P2MODE: rd_val[7:0] = p2_dir_ff;
            ioport_pkg::OFF_P3MODE: rd_val[7:0] = p3_mode_ff;
            ioport_pkg::OFF_PCFG: rd_val[7:0] = pcfg_ff;
            ioport_pkg::OFF_IRQEDGE: rd_val[7:0] = irqedge_ff;
            ioport_pkg::OFF_T8CTL: rd_val[7:0] = t8ctl_ff;
            ioport_pkg::OFF_TCCTL: rd_val[7:0] = tcctl_ff;
            ioport_pkg::OFF_T16CTL: rd_val[7:0] = t16ctl_ff;
            ioport_pkg::OFF_STATUS: rd_val[2:0] = status_ff;
            ioport_pkg::OFF_MASK: rd_val[2:0] = mask_ff;
            default: rd_hit = 1'b0;
        endcase
    end

    logic ar_have_ff;
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ar_have_ff <= 1'b0;
            ar_addr_ff <= 8'h00;
            ARREADY_O <= 1'b0;
            RVALID_O <= 1'b0;
            RDATA_O <= 32'h0;
            RRESP_O <= ioport_pkg::RESP_OKAY;
        end else begin
            ARREADY_O <= rstn & ~ar_have_ff & ~RVALID_O & ~ARREADY_O;
            if (ARVALID_I && ARREADY_O) begin
                ar_have_ff <= 1'b1;
                ar_addr_ff <= ARADDR_I;
                ARREADY_O <= 1'b0;
            end
            if (ar_have_ff) begin
                ar_have_ff <= 1'b0;
                RVALID_O <= 1'b1;
                RDATA_O <= rd_val;
                RRESP_O <= rd_hit ? ioport_pkg::RESP_OKAY
                                  : ioport_pkg::RESP_SLVERR;
            end else if (RVALID_O && RREADY_I) begin
                RVALID_O <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    pull_off_a: assert property (@(posedge CLK_I) disable iff (!rstn)
        ##1 (P0_O.pull_en & P0_O.oe) == 8'h00)
        else $error("Pull-up left on a driven pin.");
    p0_nibble_a: assert property (@(posedge CLK_I) disable iff (!rstn)
        (wb && aw_addr_ff == ioport_pkg::OFF_P0MODE && !STOP_RECOVERY_I)
        |=> p0_dir_ff == $past(wd[1:0]))
        else $error("Port 0 nibble direction not taken.");
    recov_in_a: assert property (@(posedge CLK_I) disable iff (!rstn)
        STOP_RECOVERY_I |=> p0_dir_ff == 2'b00 && !p1_dir_ff)
        else $error("Recovery did not return ports to input.");
    od_p1_a: assert property (@(posedge CLK_I) disable iff (!rstn)
        pcfg_ff[ioport_pkg::PCFG_P1_OD] |=> P1_O.out == 8'h00)
        else $error("Open-drain port 1 drove a high.");
    wake_or_a: assert property (@(posedge CLK_I) disable iff (!rstn)
        (P2_IN_I == 8'h00) |=> !WAKE_OR_O && !WAKE_AND_O)
        else $error("Wake gate wrong for all-low port 2.");
    cmp_stop_a: assert property (@(posedge CLK_I) disable iff (!rstn)
        STOP_MODE_I |=> !CMP_ENABLE_O)
        else $error("Comparators powered in stop.");
    irq_sticky_a: assert property (@(posedge CLK_I) disable iff (!rstn)
        irq_evt[0] |=> status_ff[0]
        ##1 (IRQ_O || !$past(mask_ff[0])))
        else $error("Edge event not latched or not signalled.");
    d3_analog_a: assert property (@(posedge CLK_I) disable iff (!rstn)
        analog |-> !irq_evt[1])
        else $error("Line one raised in analog mode.");
endmodule : ioport_top

// ---- test/pin_model.sv ----
// Purpose: Outside circuit on one bidirectional port.
// Assumes: Drive struct from the port, one clock.
// Notes: A pin with no driver and no pull-up toggles every cycle.
`timescale 1ns/1ps
module pin_model (
    // Clock.
    input wire logic clk_i,
    // Port drive and outside drivers.
    input wire ioport_pkg::pin_drive_t drv_i,
    input wire logic [7:0] ext_en_i,
    input wire logic [7:0] ext_val_i,
    // Resolved pin level.
    output logic [7:0] level_o
);
    logic [7:0] tog_ff = 8'h55;
    always_ff @(posedge clk_i) begin
        tog_ff <= ~tog_ff;
    end
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (drv_i.oe[i]) begin
                level_o[i] = drv_i.out[i];
            end else if (ext_en_i[i]) begin
                level_o[i] = ext_val_i[i];
            end else if (drv_i.pull_en[i]) begin
                level_o[i] = 1'b1;
            end else begin
                level_o[i] = tog_ff[i];
            end
        end
    end
endmodule : pin_model

// ---- test/testbench.sv ----
// Purpose: Register-level bench of the I/O port block.
// Assumes: AXI4-Lite master tasks, pin models on ports 0 to 2.
// Notes: Settling waits of four cycles after each pin change.
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0, rstn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, wd = 8'h00;
    logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    logic awr, wr_r, bv, arr, rv, cmpen, tedge, wk_and, wk_or, irq;
    logic [1:0] bresp, rresp, rs;
    logic [31:0] rdata, rd_v;
    ioport_pkg::pin_drive_t d0, d1, d2;
    logic [7:0] l0, l1, l2, e0 = 8'h00, e2 = 8'h00, v0 = 8'h00, v2 = 8'h00;
    logic [3:0] p3in = 4'h0;
    logic [7:4] p3out;
    logic c1 = 1'b0, c2 = 1'b0, stop = 1'b0, rec = 1'b0;
    ioport_pkg::timer_link_t tmr = 3'b000;
    logic [2:0] lines, rsrc, seen = 3'b000;
    int mismatches = 0, compares = 0, cycles = 0;
    ////////////////////////////////////////////////////////////////////////
    ioport_top ioport_top_inst (.CLK_I(clk), .RSTN_I(rstn),
        .AWADDR_I(awaddr), .AWVALID_I(awv), .AWREADY_O(awr),
        .WDATA_I({24'h000000, wd}), .WSTRB_I(4'hf), .WVALID_I(wv),
        .WREADY_O(wr_r), .BRESP_O(bresp), .BVALID_O(bv), .BREADY_I(bry),
        .ARADDR_I(araddr), .ARVALID_I(arv), .ARREADY_O(arr),
        .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rv), .RREADY_I(rry),
        .P0_IN_I(l0), .P1_IN_I(l1), .P2_IN_I(l2), .P0_O(d0), .P1_O(d1),
        .P2_O(d2), .P3_IN_I(p3in), .CMP1_RESULT_I(c1), .CMP2_RESULT_I(c2),
        .P3_OUT_O(p3out), .CMP_ENABLE_O(cmpen), .TIMER_I(tmr),
        .STOP_MODE_I(stop), .STOP_RECOVERY_I(rec), .TIMER_EDGE_O(tedge),
        .WAKE_AND_O(wk_and), .WAKE_OR_O(wk_or), .IRQ_LINES_O(lines),
        .RECOVERY_SRC_O(rsrc), .IRQ_O(irq));
    pin_model pm0_inst (.clk_i(clk), .drv_i(d0), .ext_en_i(e0),
        .ext_val_i(v0), .level_o(l0));
    pin_model pm1_inst (.clk_i(clk), .drv_i(d1), .ext_en_i(8'h00),
        .ext_val_i(8'h00), .level_o(l1));
    pin_model pm2_inst (.clk_i(clk), .drv_i(d2), .ext_en_i(e2),
        .ext_val_i(v2), .level_o(l2));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        forever #25 clk = ~clk;
    end
    always @(negedge clk) seen <= seen | lines;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            mismatches++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input string n, input logic [7:0] s, e);
        compares++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic wr(input logic [7:0] a, d);
        logic ta, tw, ha, hw;
        ta = 1'b0;
        tw = 1'b0;
        awaddr <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        while (!(ta && tw)) begin
            @(negedge clk);
            ha = awr === 1'b1;
            hw = wr_r === 1'b1;
            @(posedge clk);
            if (ha) begin
                ta = 1'b1;
                awv <= 1'b0;
            end
            if (hw) begin
                tw = 1'b1;
                wv <= 1'b0;
            end
        end
        do begin
            @(negedge clk);
            ha = bv === 1'b1;
            rs = bresp;
            @(posedge clk);
        end while (!ha);
        chk("bresp", {6'h00, rs}, {6'h00, ioport_pkg::RESP_OKAY});
        bry <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        logic h;
        araddr <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        do begin
            @(negedge clk);
            h = arr === 1'b1;
            @(posedge clk);
        end while (!h);
        arv <= 1'b0;
        do begin
            @(negedge clk);
            h = rv === 1'b1;
            rd_v = rdata;
            rs = rresp;
            @(posedge clk);
        end while (!h);
        rry <= 1'b0;
        @(posedge clk);
    endtask : rd
    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] pat [3];
        pat = '{8'hff, 8'h00, 8'h01};
        cyc(12);
        rstn <= 1'b1;
        cyc(6);
        chk("p0 oe", d0.oe, 8'h00);
        chk("p1 oe", d1.oe, 8'h00);
        chk("p2 oe", d2.oe, 8'h00);
        $display("reset test done");
        e0 <= 8'hf0;
        v0 <= 8'h30;
        wr(ioport_pkg::OFF_PORT0, 8'ha5);
        wr(ioport_pkg::OFF_P0MODE, 8'h01);
        cyc(4);
        chk("p0 oe", d0.oe, 8'h0f);
        chk("p0 pull", d0.pull_en & d0.oe, 8'h00);
        rd(ioport_pkg::OFF_PORT0);
        chk("p0 read", rd_v[7:0], 8'h35);
        wr(ioport_pkg::OFF_PCFG, 8'h04);
        cyc(4);
        chk("p0 od oe", d0.oe, 8'h0a);
        wr(ioport_pkg::OFF_PORT1, 8'h3c);
        wr(ioport_pkg::OFF_P1MODE, 8'h01);
        wr(ioport_pkg::OFF_PCFG, 8'h02);
        cyc(4);
        chk("p1 od oe", d1.oe, 8'hc3);
        wr(ioport_pkg::OFF_PORT2, 8'h00);
        wr(ioport_pkg::OFF_P2MODE, 8'h81);
        wr(ioport_pkg::OFF_PCFG, 8'h08);
        cyc(4);
        chk("p2 oe lo", d2.oe, 8'h81);
        wr(ioport_pkg::OFF_PORT2, 8'hff);
        cyc(4);
        chk("p2 oe hi", d2.oe, 8'h00);
        rec <= 1'b1;
        cyc(1);
        rec <= 1'b0;
        cyc(4);
        chk("p0 rec oe", d0.oe, 8'h00);
        chk("p1 rec oe", d1.oe, 8'h00);
        $display("direction test done");
        wr(ioport_pkg::OFF_P2MODE, 8'h00);
        wr(ioport_pkg::OFF_PCFG, 8'h00);
        e2 <= 8'hff;
        for (int i = 0; i < 3; i++) begin
            v2 <= pat[i];
            cyc(4);
            chk("wake and", {7'h00, wk_and}, {7'h00, pat[i] == 8'hff});
            chk("wake or", {7'h00, wk_or}, {7'h00, pat[i] != 8'h00});
        end
        p3in <= 4'h2;
        v2 <= 8'h00;
        cyc(4);
        chk("edge p3", {7'h00, tedge}, 8'h01);
        wr(ioport_pkg::OFF_TCCTL, 8'h40);
        cyc(4);
        chk("edge p2", {7'h00, tedge}, 8'h00);
        tmr <= 3'b110;
        wr(ioport_pkg::OFF_T8CTL, 8'h01);
        wr(ioport_pkg::OFF_T16CTL, 8'h01);
        cyc(4);
        chk("timer outs", {6'h00, p3out[5:4]}, 8'h03);
        v2 <= 8'h01;
        tmr <= 3'b100;
        wr(ioport_pkg::OFF_TCCTL, 8'h60);
        cyc(4);
        chk("out6 or", {7'h00, p3out[6]}, 8'h01);
        wr(ioport_pkg::OFF_TCCTL, 8'h50);
        cyc(4);
        chk("out6 and", {7'h00, p3out[6]}, 8'h00);
        wr(ioport_pkg::OFF_T8CTL, 8'h00);
        wr(ioport_pkg::OFF_P3MODE, 8'h02);
        cyc(4);
        chk("cmp on", {7'h00, cmpen}, 8'h01);
        chk("rec src an", {5'h00, rsrc}, 8'h00);
        stop <= 1'b1;
        cyc(4);
        chk("cmp stop", {7'h00, cmpen}, 8'h00);
        stop <= 1'b0;
        c1 <= 1'b1;
        c2 <= 1'b1;
        wr(ioport_pkg::OFF_PCFG, 8'h11);
        cyc(4);
        chk("cmp outs", {6'h00, p3out[7], p3out[4]}, 8'h03);
        $display("port3 test done");
        p3in <= 4'h0;
        wr(ioport_pkg::OFF_P3MODE, 8'h00);
        wr(ioport_pkg::OFF_MASK, 8'hff);
        for (int s = 0; s < 3; s++) begin
            wr(ioport_pkg::OFF_IRQEDGE, 8'(s << 6));
            wr(ioport_pkg::OFF_STATUS, 8'hff);
            seen = 3'b000;
            p3in <= 4'h4;
            cyc(4);
            chk("rise", {7'h00, seen[0]}, {7'h00, s != 1});
            seen = 3'b000;
            p3in <= 4'h0;
            cyc(4);
            chk("fall", {7'h00, seen[0]}, {7'h00, s != 0});
            chk("irq", {7'h00, irq}, 8'h01);
        end
        p3in <= 4'h8;
        cyc(4);
        chk("rec src", {5'h00, rsrc}, 8'h04);
        seen = 3'b000;
        p3in <= 4'h0;
        cyc(4);
        chk("line one", {7'h00, seen[1]}, 8'h01);
        wr(ioport_pkg::OFF_STATUS, 8'hff);
        cyc(2);
        chk("irq clr", {7'h00, irq}, 8'h00);
        rd(8'h3c);
        chk("unmapped", {6'h00, rs}, {6'h00, ioport_pkg::RESP_SLVERR});
        chk("unmapped data", rd_v[7:0], 8'h00);
        $display("interrupt test done");
        end_of_test();
    end
endmodule : testbench
